// ===== include/rbg_map.svh
/*
 constants for the host-side reset and first-access gate of a flash drive.
 assumes a 100 MHz system clock; included by its bare name.
*/
`ifndef RBG_MAP_SVH
`define RBG_MAP_SVH

`define RBG_CLK_PERIOD_NS     10
// least reset low pulse, in ns
`define RBG_RST_LOW_NS        50
`define RBG_RST_LOW_CYC       ((`RBG_RST_LOW_NS + `RBG_CLK_PERIOD_NS - 1) / `RBG_CLK_PERIOD_NS)
// least time from reset release to address-valid rise, in us
`define RBG_AVD_SETUP_US      3
`define RBG_AVD_SETUP_CYC     ((`RBG_AVD_SETUP_US * 1000 + `RBG_CLK_PERIOD_NS - 1) / `RBG_CLK_PERIOD_NS)
// longest busy-release time, in ms
`define RBG_BUSY_REL_MS       75
`define RBG_BUSY_REL_CYC      (`RBG_BUSY_REL_MS * 1000000 / `RBG_CLK_PERIOD_NS)
// counter width for all timers
`define RBG_CNT_W             24
// method codes
`define RBG_METH_WAIT         2'h0
`define RBG_METH_POLL         2'h1
`define RBG_METH_STALL        2'h2

`endif

// ===== include/rbg_pkg.sv
/*
 types for the host-side reset and first-access gate.
 assumes rbg_map.svh is on the include path.
*/
`default_nettype none

package rbg_pkg;
   typedef enum logic [2:0]
   {
      RBG_IDLE  = 3'b000,
      RBG_RESET = 3'b001,
      RBG_BOOT  = 3'b010,
      RBG_READY = 3'b011
   } rbg_state_type;

   typedef enum logic [1:0]
   {
      RBG_M_WAIT  = 2'b00,
      RBG_M_POLL  = 2'b01,
      RBG_M_STALL = 2'b10
   } rbg_method_type;
endpackage

`default_nettype wire

// ===== rtl/rbg_timer.sv
/*
 down-counting timer: loads a count on start, pulses done the cycle after it reaches one.
 assumes one clock, asynchronous active-high reset.
*/
`default_nettype none
`include "rbg_map.svh"

module rbg_timer
(
   input  wire logic                   mclk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   start_i,
   input  wire logic [`RBG_CNT_W-1:0]  load_i,
   output logic                        running_o,
   output logic                        done_o
);
   logic [`RBG_CNT_W-1:0] cnt_reg;
   logic                  run_reg;

   // count down while running, done is one cycle at the end
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_o  <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            cnt_reg <= load_i;
            run_reg <= 1'b1;
         end
         else if (run_reg)
         begin
            if (cnt_reg <= `RBG_CNT_W'(1))
            begin
               run_reg <= 1'b0;
               done_o  <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg - `RBG_CNT_W'(1);
         end
      end
   end

   assign running_o = run_reg;
endmodule

`default_nettype wire

// ===== rtl/rbg_host_gate.sv
/*
 host-side reset sequencer and first-access gate for an embedded flash drive.
 drives the active-low reset pin, watches busy, and holds back the host's
 first access (chip/output enable and address-valid strobe) until safe.
 assumes busy arrives from a pin, asynchronous to mclk_i.
*/
`default_nettype none
`include "rbg_map.svh"

module rbg_host_gate
   import rbg_pkg::*;
(
   input  wire logic                   mclk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   reset_req_i,
   input  wire rbg_pkg::rbg_method_type method_i,
   input  wire logic                   muxed_bus_i,
   input  wire logic                   busy_n_i,
   input  wire logic                   acc_req_i,
   input  wire logic                   acc_write_i,
   input  wire logic                   ce_n_req_i,
   input  wire logic                   oe_n_req_i,
   input  wire logic                   avd_n_req_i,
   output logic                        host_reset_in_n_o,
   output logic                        ce_n_o,
   output logic                        oe_n_o,
   output logic                        address_valid_strobe_n_o,
   output logic                        acc_ready_o,
   output logic                        host_wait_o,
   output logic                        acc_refused_o,
   output logic                        device_ready_o,
   output logic                        busy_timeout_o
);
   import rbg_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // busy synchroniser
   logic busy_meta_reg;
   logic busy_sync_reg;

   // two flops before anything reads busy
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         busy_meta_reg <= 1'b0;
         busy_sync_reg <= 1'b0;
      end
      else
      begin
         busy_meta_reg <= busy_n_i;
         busy_sync_reg <= busy_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   rbg_state_type  state_reg;
   rbg_state_type  state_next;
   rbg_method_type meth_reg;
   logic           muxed_reg;
   logic           avd_ok_reg;
   logic           first_done_reg;
   logic           timer_start;
   logic [`RBG_CNT_W-1:0] timer_load;
   logic           timer_run;
   logic           timer_done;
   logic           avd_start;
   logic           avd_run;
   logic           avd_done;

   // reset pulse timer, then busy-release timer
   rbg_timer u_main_timer
   (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (timer_start),
      .load_i    (timer_load),
      .running_o (timer_run),
      .done_o    (timer_done)
   );

   // address-valid setup timer from reset release
   rbg_timer u_avd_timer
   (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (avd_start),
      .load_i    (`RBG_CNT_W'(`RBG_AVD_SETUP_CYC)),
      .running_o (avd_run),
      .done_o    (avd_done)
   );

   // busy is seen released only once synchronised high
   function automatic logic boot_finished(input rbg_method_type m, input logic busy_h, input logic tdone);
      if (m == RBG_M_WAIT)
         boot_finished = tdone;
      else
         boot_finished = busy_h;
   endfunction

   // next state
   always_comb
   begin
      state_next  = state_reg;
      timer_start = 1'b0;
      timer_load  = `RBG_CNT_W'(`RBG_RST_LOW_CYC);
      avd_start   = 1'b0;
      case (state_reg)
         RBG_IDLE:
         begin
            state_next  = RBG_RESET;
            timer_start = 1'b1;
         end
         RBG_RESET:
            if (timer_done && !reset_req_i)
            begin
               state_next  = RBG_BOOT;
               timer_start = 1'b1;
               timer_load  = `RBG_CNT_W'(`RBG_BUSY_REL_CYC);
               avd_start   = 1'b1;
            end
            else if (timer_done)
               timer_start = 1'b1;
         RBG_BOOT:
            if (reset_req_i)
               state_next = RBG_IDLE;
            else if (boot_finished(meth_reg, busy_sync_reg, timer_done) && !timer_start)
               state_next = RBG_READY;
         RBG_READY:
            if (reset_req_i)
               state_next = RBG_IDLE;
         default:
            state_next = RBG_IDLE;
      endcase
   end

   // state and latched mode
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= RBG_IDLE;
         meth_reg  <= RBG_M_STALL;
         muxed_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg == RBG_IDLE)
         begin
            meth_reg  <= method_i;
            muxed_reg <= muxed_bus_i;
         end
      end
   end

   // on a muxed bus, address-valid permitted only once setup time has passed
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         avd_ok_reg <= 1'b0;
      else if (state_reg == RBG_IDLE || avd_start)
         avd_ok_reg <= 1'b0;
      else if (avd_done)
         avd_ok_reg <= 1'b1;
   end

   // first access after boot is tracked for every method
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         first_done_reg <= 1'b0;
      else if (state_reg != RBG_READY)
         first_done_reg <= 1'b0;
      else if (acc_req_i && !acc_write_i)
         first_done_reg <= 1'b1;
   end

   // reset pin low in idle and reset states
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         host_reset_in_n_o <= 1'b0;
      else
         host_reset_in_n_o <= (state_next == RBG_BOOT) || (state_next == RBG_READY);
   end

   ////////////////////////////////////////////////////////////////////////
   // access gate
   logic ready;
   logic stall_ok;
   logic gate_open;
   logic avd_open;

   assign ready    = (state_reg == RBG_READY);
   // every mode: only a read may be the first access
   assign stall_ok = first_done_reg || !acc_write_i;
   assign gate_open = ready && stall_ok;
   assign avd_open  = gate_open && (!muxed_reg || avd_ok_reg);

   // pins: enables forced high while gate is shut
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ce_n_o                   <= 1'b1;
         oe_n_o                   <= 1'b1;
         address_valid_strobe_n_o <= 1'b1;
      end
      else
      begin
         ce_n_o                   <= gate_open ? ce_n_req_i : 1'b1;
         oe_n_o                   <= gate_open ? oe_n_req_i : 1'b1;
         address_valid_strobe_n_o <= avd_open ? avd_n_req_i : 1'b1;
      end
   end

   // status flags
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         device_ready_o <= 1'b0;
         busy_timeout_o <= 1'b0;
      end
      else
      begin
         device_ready_o <= (state_next == RBG_READY);
         if (state_reg == RBG_IDLE)
            busy_timeout_o <= 1'b0;
         else if (state_reg == RBG_BOOT && timer_done && meth_reg != RBG_M_WAIT && !busy_sync_reg)
            busy_timeout_o <= 1'b1;    // device overran the longest busy time
      end
   end

   // handshake back to the host core
   assign acc_ready_o   = avd_open;
   assign host_wait_o   = acc_req_i && !avd_open && (meth_reg == RBG_M_STALL);
   assign acc_refused_o = acc_req_i && !avd_open && (meth_reg != RBG_M_STALL);
endmodule

`default_nettype wire

// ===== tb/rbg_host_gate_assertions.sv
/*
 checker for the host reset gate, bound to its top module.
 assumes one clock and a busy pin from the device model.
*/
`default_nettype none
module rbg_host_gate_assertions
(
   input wire logic                    mclk_i,
   input wire logic                    sys_rst_i,
   input wire rbg_pkg::rbg_method_type method_i,
   input wire logic                    muxed_bus_i,
   input wire logic                    busy_n_i,
   input wire logic                    acc_req_i,
   input wire logic                    acc_write_i,
   input wire logic                    host_reset_in_n_o,
   input wire logic                    ce_n_o,
   input wire logic                    oe_n_o,
   input wire logic                    address_valid_strobe_n_o,
   input wire logic                    acc_ready_o,
   input wire logic                    host_wait_o,
   input wire logic                    acc_refused_o,
   input wire logic                    device_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import rbg_pkg::*;
   logic [15:0] rel_cnt_reg;
   // cycles since the reset pin was released, saturating
   always_ff @(posedge mclk_i or posedge sys_rst_i)
      if (sys_rst_i || !host_reset_in_n_o)
         rel_cnt_reg <= 16'h0000;
      else if (rel_cnt_reg != 16'hffff)
         rel_cnt_reg <= rel_cnt_reg + 16'h0001;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////
   a_rst_low_width: assert property ($fell(host_reset_in_n_o) |-> !host_reset_in_n_o [*5])
      else $error("reset pin pulse too short");
   a_shut_enables: assert property ((!device_ready_o && !$past(device_ready_o)) |-> (ce_n_o && oe_n_o))
      else $error("enables driven before ready");
   // the timed wait method may open without busy, so only poll and stall are held to busy
   a_ready_sync: assert property (($rose(device_ready_o) && (method_i != RBG_M_WAIT)) |-> $past(busy_n_i, 2))
      else $error("ready without synchronised busy");
   a_busy_hold: assert property ((!busy_n_i && !device_ready_o && (method_i != RBG_M_WAIT)) |=>
      !device_ready_o [*2])
      else $error("ready while busy");
   a_first_read: assert property (($rose(device_ready_o) && acc_req_i && acc_write_i) |-> !acc_ready_o)
      else $error("write let through as first access");
   a_gate_shut: assert property (!device_ready_o |-> !acc_ready_o)
      else $error("access open before ready");
   a_avd_setup: assert property ((muxed_bus_i && !address_valid_strobe_n_o) |-> rel_cnt_reg >= 16'h012b)
      else $error("strobe too soon after release");
   a_stall_hold: assert property ((acc_req_i && !device_ready_o && method_i == RBG_M_STALL) |->
      (host_wait_o && !acc_ready_o))
      else $error("stall not held");
   a_refuse_flag: assert property ((acc_req_i && !device_ready_o && method_i != RBG_M_STALL) |->
      (acc_refused_o && !acc_ready_o && !host_wait_o))
      else $error("access not refused");
endmodule
bind rbg_host_gate rbg_host_gate_assertions u_chk (.mclk_i, .sys_rst_i, .method_i, .muxed_bus_i, .busy_n_i,
   .acc_req_i, .acc_write_i, .host_reset_in_n_o, .ce_n_o, .oe_n_o, .address_valid_strobe_n_o, .acc_ready_o,
   .host_wait_o,
   .acc_refused_o, .device_ready_o);
`default_nettype wire

// ===== tb/rbg_dev_model.sv
/*
 behavioural flash drive: busy falls with the reset pin, rises after boot load.
 assumes the bench gives the boot length in clock cycles.
*/
`default_nettype none
module rbg_dev_model
(
   input  wire logic        mclk_i,
   input  wire logic        host_reset_in_n_i,
   input  wire logic [15:0] boot_cyc_i,
   output var  logic        busy_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_reg;
   // busy drops at once; boot load ignores accesses until done, well inside 75 ms
   always @(posedge mclk_i or negedge host_reset_in_n_i)
      if (!host_reset_in_n_i)
      begin
         cnt_reg <= 16'h0000;
         busy_n_o <= 1'b0;
      end
      else if (cnt_reg < boot_cyc_i)
         cnt_reg <= cnt_reg + 16'h0001;
      else
         busy_n_o <= 1'b1;
endmodule
`default_nettype wire

// ===== tb/rbg_host_gate_tb.sv
/*
 bench for the host reset gate: random boot times, all three methods.
 assumes the device model drives busy.
*/
`default_nettype none
module rbg_host_gate_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rbg_pkg::*;
   logic mclk_i = 0, sys_rst_i = 1, reset_req_i = 0, muxed_bus_i = 0, acc_req_i = 0, acc_write_i = 0;
   logic ce_n_req_i = 1, oe_n_req_i = 1, avd_n_req_i = 1;
   logic busy_n, rst_n, ce_n, oe_n, avd_n, rdy_o, wait_o, ref_o, tmo_o, acc_rdy;
   rbg_method_type method_i = RBG_M_POLL;
   logic [15:0] boot = 16'h0010;
   logic [31:0] seed = 32'h0000005d, q[$];
   int miscompares = 0, n_checks = 0;
   time t_busy = 0, t_low = 0;
   always #5 mclk_i = ~mclk_i;
   rbg_host_gate u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reset_req_i(reset_req_i), .method_i(method_i),
      .muxed_bus_i(muxed_bus_i), .busy_n_i(busy_n), .acc_req_i(acc_req_i), .acc_write_i(acc_write_i),
      .ce_n_req_i(ce_n_req_i), .oe_n_req_i(oe_n_req_i), .avd_n_req_i(avd_n_req_i), .host_reset_in_n_o(rst_n),
      .ce_n_o(ce_n), .oe_n_o(oe_n), .address_valid_strobe_n_o(avd_n), .acc_ready_o(acc_rdy), .host_wait_o(wait_o),
      .acc_refused_o(ref_o), .device_ready_o(rdy_o), .busy_timeout_o(tmo_o));
   rbg_dev_model u_dev (.mclk_i(mclk_i), .host_reset_in_n_i(rst_n), .boot_cyc_i(boot), .busy_n_o(busy_n));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // ready delay after busy rise, against the oldest note
   always @(posedge busy_n) t_busy = $time;
   always @(posedge rdy_o)
      if (q.size() > 0)
         chk("ready_delay", q.pop_front(), 32'(($time - t_busy) / 10));
   // reset pin low width
   always @(negedge rst_n) t_low = $time;
   always @(posedge rst_n) chk("rst_low_ok", 1, 32'(($time - t_low) >= 50));
   // watchdog
   initial
   begin
      #500000;
      miscompares++;
      results();
   end
   // stimulus: wait, poll, stall, twice each
   initial
   begin
      repeat (4) @(negedge mclk_i);
      sys_rst_i = 0;
      for (int i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         method_i = rbg_method_type'(2'(i % 3));
         muxed_bus_i = seed[0];
         boot = {9'h000, seed[14:8]} + (seed[1] ? 16'h001e : 16'h01a4);
         acc_req_i = 0;
         reset_req_i = 1;
         repeat (3) @(negedge mclk_i);
         reset_req_i = 0;
         if (method_i != RBG_M_WAIT)
            q.push_back(3);
         repeat (2) @(negedge mclk_i);
         acc_req_i = 1;
         ce_n_req_i = 0;
         oe_n_req_i = 0;
         avd_n_req_i = 0;
         for (int k = 0; k < 20; k++)
         begin
            @(negedge mclk_i);
            chk("ce_oe_shut", 2'b11, {ce_n, oe_n});
            chk("held_off", 1, method_i == RBG_M_STALL ? wait_o : ref_o);
            chk("acc_shut", 0, acc_rdy);
         end
         if (method_i == RBG_M_WAIT)
         begin
            repeat (int'(boot) + 20) @(negedge mclk_i);
            chk("wait_not_ready", 0, rdy_o);
            continue;
         end
         // a write stands pending at ready, so the read-first gate must hold it
         acc_write_i = 1;
         for (int k = 0; k < 2000 && rdy_o !== 1'b1; k++)
            @(negedge mclk_i);
         chk("ready", 1, rdy_o);
         chk("no_timeout", 0, tmo_o);
         @(negedge mclk_i);
         chk("write_first_shut", 2'b11, {ce_n, oe_n});
         chk("write_first_held", 1, method_i == RBG_M_STALL ? wait_o : ref_o);
         chk("write_first_acc", 0, acc_rdy);
         // the read now goes first and opens the gate
         acc_write_i = 0;
         @(negedge mclk_i);
         for (int k = 0; k < 8; k++)
         begin
            seed = xs(seed);
            ce_n_req_i = seed[0];
            oe_n_req_i = seed[1];
            acc_write_i = seed[2];
            @(negedge mclk_i);
            chk("ce_oe_follow", {seed[0], seed[1]}, {ce_n, oe_n});
         end
         chk("avd_gate", (muxed_bus_i && boot < 16'h012c) ? 1 : 0, avd_n);
         repeat (300) @(negedge mclk_i);
         chk("avd_late", 0, avd_n);
         chk("acc_open", 1, acc_rdy);
      end
      results();
   end
endmodule
`default_nettype wire
